// File: verilog/pswr_pkg.sv
package pswr_pkg;

  // ==========================================================
  // Packet layout
  localparam int PSWR_CH_BITS = 14;
  localparam int PSWR_PKT_BITS = 28;
  localparam int PSWR_SIG_LSB = 14;
  localparam int PSWR_PKT_MSB = 27;

  // ==========================================================
  // Device timing, in internal clock cycles, and converter range limits
  localparam int PSWR_CONV_PERIOD = 32;
  localparam int PSWR_START_CYCLES = 3;
  localparam int PSWR_FORCE_PERIOD = 512;
  localparam int PSWR_SHORT_CYCLES = 512;
  localparam int PSWR_DRIVE_CYCLES = 8;
  localparam int PSWR_LOW_END_CYCLES = 1;
  localparam logic [13:0] PSWR_RANGE_HI = 14'h3E00;
  localparam logic [13:0] PSWR_RANGE_LO = 14'h01FF;

  // ==========================================================
  // Host timing, in ns, and cycle counts at the host clock
  localparam int PSWR_CLK_NS = 20;
  localparam int PSWR_T_SETUP_NS = 110000;
  localparam int PSWR_T_LOW_NS = 200;
  localparam int PSWR_T_HIGH_NS = 200;
  localparam int PSWR_T_REL_NS = 100;
  localparam int PSWR_T_END_NS = 50000;
  localparam int PSWR_T_INTERVAL_NS = 2000000;
  localparam int PSWR_SETUP_CYC = (PSWR_T_SETUP_NS + PSWR_CLK_NS - 1) / PSWR_CLK_NS;
  localparam int PSWR_LOW_CYC = (PSWR_T_LOW_NS + PSWR_CLK_NS - 1) / PSWR_CLK_NS;
  localparam int PSWR_HIGH_CYC = (PSWR_T_HIGH_NS + PSWR_CLK_NS - 1) / PSWR_CLK_NS;
  localparam int PSWR_REL_CYC = (PSWR_T_REL_NS + PSWR_CLK_NS - 1) / PSWR_CLK_NS;
  localparam int PSWR_END_CYC = (PSWR_T_END_NS + PSWR_CLK_NS - 1) / PSWR_CLK_NS;
  localparam int PSWR_INTERVAL_CYC = PSWR_T_INTERVAL_NS / PSWR_CLK_NS;

  // ==========================================================
  // State encodings
  typedef enum logic {PSWR_D_IDLE, PSWR_D_XFER} pswr_dev_state_t;
  typedef enum logic [2:0] {
    PSWR_H_IDLE, PSWR_H_SETUP, PSWR_H_LOW, PSWR_H_HIGH, PSWR_H_REL, PSWR_H_END
  } pswr_host_state_t;

endpackage

// File: verilog/pswr_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pswr_link_if;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  logic shared_line_short;

  // ==========================================================
  // Wire resolution: host wins, released line reads low
  assign shared_line_short = host_oe ? host_o : (dev_oe ? dev_o : 1'b0);

  modport host (output host_o, output host_oe, input shared_line_short);
  modport dev (output dev_o, output dev_oe, input shared_line_short);
endinterface
`default_nettype wire

// File: verilog/pswr_device.sv
`timescale 1ns/10ps
`default_nettype none
module pswr_device
  import pswr_pkg::*;
#(
  parameter int CONV_PERIOD = PSWR_CONV_PERIOD,
  parameter int START_CYCLES = PSWR_START_CYCLES,
  parameter int FORCE_PERIOD = PSWR_FORCE_PERIOD,
  parameter int SHORT_CYCLES = PSWR_SHORT_CYCLES,
  parameter int DRIVE_CYCLES = PSWR_DRIVE_CYCLES,
  parameter int LOW_END_CYCLES = PSWR_LOW_END_CYCLES
) (
  input wire logic dev_clk, // Internal oscillator, the link clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [13:0] sig_in, // Converter signal channel
  input wire logic [13:0] temp_in, // Converter temperature channel
  pswr_link_if.dev link, // Shared line
  output logic conv_short, // Converter input shorted
  output logic busy // Readout in progress
);

  localparam int CW = $clog2(CONV_PERIOD);
  localparam int FW = $clog2(FORCE_PERIOD);
  localparam int SW = $clog2(SHORT_CYCLES + 1);
  localparam int DW = $clog2(DRIVE_CYCLES + 1);
  localparam int LW = $clog2(LOW_END_CYCLES + 1);
  localparam int HW = $clog2(START_CYCLES + 1);

  // ==========================================================
  // Line synchroniser
  logic line_meta;
  logic line_sync;
  logic line_prev;
  logic rise;

  // Two flops before any logic looks at the line
  always_ff @(posedge dev_clk) begin
    if (reset) begin
      line_meta <= 1'b0;
      line_sync <= 1'b0;
      line_prev <= 1'b0;
    end else if (ce) begin
      line_meta <= link.shared_line_short;
      line_sync <= line_meta;
      line_prev <= line_sync;
    end
  end

  // Host clock edge on the shared line
  assign rise = line_sync & ~line_prev;

  // ==========================================================
  // Converter sampling and out-of-range recovery
  logic [CW-1:0] conv_cnt;
  logic [CW-1:0] next_conv_cnt;
  logic [PSWR_PKT_BITS-1:0] conv_reg;
  logic [PSWR_PKT_BITS-1:0] next_conv_reg;
  logic [SW-1:0] short_cnt;
  logic [SW-1:0] next_short_cnt;
  logic next_conv_short;
  logic conv_tick;
  logic out_range;
  logic [13:0] sig_meta;
  logic [13:0] sig_sync;
  logic [13:0] temp_meta;
  logic [13:0] temp_sync;

  // Converter levels come from another domain; two flops before use
  always_ff @(posedge dev_clk) begin
    if (reset) begin
      sig_meta <= '0;
      sig_sync <= '0;
      temp_meta <= '0;
      temp_sync <= '0;
    end else if (ce) begin
      sig_meta <= sig_in;
      sig_sync <= sig_meta;
      temp_meta <= temp_in;
      temp_sync <= temp_meta;
    end
  end

  // Sample tick, channel packing and short counter
  always_comb begin
    conv_tick = (conv_cnt == CW'(CONV_PERIOD - 1));
    next_conv_cnt = conv_tick ? '0 : conv_cnt + 1'b1;
    next_conv_reg = conv_reg;
    out_range = (sig_sync > PSWR_RANGE_HI) || (sig_sync < PSWR_RANGE_LO);
    next_short_cnt = short_cnt;
    if (short_cnt != '0) begin
      next_short_cnt = short_cnt - 1'b1;
    end
    if (conv_tick) begin
      next_conv_reg = {sig_sync, temp_sync};
      if (out_range) begin
        next_short_cnt = SW'(SHORT_CYCLES);
      end
    end
    next_conv_short = (next_short_cnt != '0);
  end

  // Register converter state
  always_ff @(posedge dev_clk) begin
    if (reset) begin
      conv_cnt <= '0;
      conv_reg <= '0;
      short_cnt <= '0;
      conv_short <= 1'b0;
    end else if (ce) begin
      conv_cnt <= next_conv_cnt;
      conv_reg <= next_conv_reg;
      short_cnt <= next_short_cnt;
      conv_short <= next_conv_short;
    end
  end

  // ==========================================================
  // Readout state machine, output latch and line drive
  pswr_dev_state_t state;
  pswr_dev_state_t next_state;
  logic [PSWR_PKT_BITS-1:0] out_latch;
  logic [PSWR_PKT_BITS-1:0] next_out_latch;
  logic [HW-1:0] high_cnt;
  logic [HW-1:0] next_high_cnt;
  logic [LW-1:0] low_cnt;
  logic [LW-1:0] next_low_cnt;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic [DW-1:0] drv_cnt;
  logic [DW-1:0] next_drv_cnt;
  logic drv_bit;
  logic next_drv_bit;
  logic [FW-1:0] force_cnt;
  logic [FW-1:0] next_force_cnt;
  logic next_force;
  logic next_dev_o;
  logic next_dev_oe;
  logic next_busy;
  logic [4:0] bit_pos;

  // Next state of the readout logic
  always_comb begin
    next_state = state;
    next_out_latch = out_latch;
    next_high_cnt = high_cnt;
    next_low_cnt = low_cnt;
    next_bit_cnt = bit_cnt;
    next_drv_cnt = drv_cnt;
    next_drv_bit = drv_bit;
    bit_pos = 5'(PSWR_PKT_MSB) - bit_cnt;
    if (drv_cnt != '0) begin
      next_drv_cnt = drv_cnt - 1'b1;
    end
    unique case (state)
      PSWR_D_IDLE: begin
        next_low_cnt = '0;
        if (line_sync) begin
          if (high_cnt >= HW'(START_CYCLES - 1)) begin
            next_state = PSWR_D_XFER;
            next_bit_cnt = '0;
            next_high_cnt = '0;
          end else begin
            next_high_cnt = high_cnt + 1'b1;
          end
        end else begin
          next_high_cnt = '0;
          next_out_latch = conv_reg;
        end
      end
      PSWR_D_XFER: begin
        // A rising edge hands out the next bit, most significant first
        if (rise && bit_cnt < 5'(PSWR_PKT_BITS)) begin
          next_drv_bit = out_latch[bit_pos];
          next_drv_cnt = DW'(DRIVE_CYCLES);
          next_bit_cnt = bit_cnt + 1'b1;
        end
        // A low held by the host ends or cancels the readout
        if (!line_sync && drv_cnt == '0) begin
          if (low_cnt >= LW'(LOW_END_CYCLES - 1)) begin
            next_state = PSWR_D_IDLE;
            next_low_cnt = '0;
          end else begin
            next_low_cnt = low_cnt + 1'b1;
          end
        end else begin
          next_low_cnt = '0;
        end
      end
    endcase
    next_busy = (next_state == PSWR_D_XFER);
  end

  // Periodic forced high, never over a data bit
  always_comb begin
    next_force_cnt = force_cnt + 1'b1;
    next_force = (force_cnt == FW'(FORCE_PERIOD - 1)) && (next_drv_cnt == '0);
    next_dev_oe = (next_drv_cnt != '0) || next_force;
    next_dev_o = (next_drv_cnt != '0) ? next_drv_bit : 1'b1;
  end

  // Register readout state and pin drive
  always_ff @(posedge dev_clk) begin
    if (reset) begin
      state <= PSWR_D_IDLE;
      out_latch <= '0;
      high_cnt <= '0;
      low_cnt <= '0;
      bit_cnt <= '0;
      drv_cnt <= '0;
      drv_bit <= 1'b0;
      force_cnt <= '0;
      busy <= 1'b0;
      link.dev_o <= 1'b0;
      link.dev_oe <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      out_latch <= next_out_latch;
      high_cnt <= next_high_cnt;
      low_cnt <= next_low_cnt;
      bit_cnt <= next_bit_cnt;
      drv_cnt <= next_drv_cnt;
      drv_bit <= next_drv_bit;
      force_cnt <= next_force_cnt;
      busy <= next_busy;
      link.dev_o <= next_dev_o;
      link.dev_oe <= next_dev_oe;
    end
  end

endmodule
`default_nettype wire

// File: verilog/pswr_host.sv
`timescale 1ns/10ps
`default_nettype none
module pswr_host
  import pswr_pkg::*;
#(
  parameter int SETUP_CYC = PSWR_SETUP_CYC,
  parameter int LOW_CYC = PSWR_LOW_CYC,
  parameter int HIGH_CYC = PSWR_HIGH_CYC,
  parameter int REL_CYC = PSWR_REL_CYC,
  parameter int END_CYC = PSWR_END_CYC,
  parameter int INTERVAL_CYC = PSWR_INTERVAL_CYC
) (
  input wire logic clk, // Host clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic start, // Read one packet, taken when idle
  input wire logic auto_en, // Read packets at a fixed interval
  input wire logic [4:0] nbits, // Bits to read, 0 or over 28 means 28
  pswr_link_if.host link, // Shared line
  output logic busy, // Readout in progress
  output logic done, // One-cycle pulse, results valid
  output logic [13:0] sig_out, // Signal channel
  output logic [13:0] temp_out // Temperature channel
);

  localparam int TW = 24;

  // ==========================================================
  // Line synchroniser
  logic line_meta;
  logic line_sync;

  // Two flops before the bit sampler
  always_ff @(posedge clk) begin
    if (reset) begin
      line_meta <= 1'b0;
      line_sync <= 1'b0;
    end else if (ce) begin
      line_meta <= link.shared_line_short;
      line_sync <= line_meta;
    end
  end

  // ==========================================================
  // Readout sequencer
  pswr_host_state_t state;
  pswr_host_state_t next_state;
  logic [TW-1:0] timer;
  logic [TW-1:0] next_timer;
  logic [TW-1:0] ival;
  logic [TW-1:0] next_ival;
  logic [4:0] idx;
  logic [4:0] next_idx;
  logic [4:0] req;
  logic [4:0] next_req;
  logic [PSWR_PKT_BITS-1:0] rx;
  logic [PSWR_PKT_BITS-1:0] next_rx;
  logic next_done;
  logic next_o;
  logic next_oe;
  logic go;
  logic [13:0] next_sig;
  logic [13:0] next_temp;

  // Bit timing and sampling
  always_comb begin
    next_state = state;
    next_timer = (timer != '0) ? timer - 1'b1 : timer;
    next_idx = idx;
    next_req = req;
    next_rx = rx;
    next_done = 1'b0;
    next_sig = sig_out;
    next_temp = temp_out;
    // Interval counter keeps readouts evenly spaced
    next_ival = (ival == '0) ? TW'(INTERVAL_CYC - 1) : ival - 1'b1;
    go = start || (auto_en && ival == '0);
    unique case (state)
      PSWR_H_IDLE: begin
        if (go) begin
          next_state = PSWR_H_SETUP;
          next_timer = TW'(SETUP_CYC - 1);
          next_idx = '0;
          next_rx = '0;
          next_req = (nbits == '0 || nbits > 5'(PSWR_PKT_BITS)) ? 5'(PSWR_PKT_BITS) : nbits;
        end
      end
      PSWR_H_SETUP: begin
        if (timer == '0) begin
          next_state = PSWR_H_LOW;
          next_timer = TW'(LOW_CYC - 1);
        end
      end
      PSWR_H_LOW: begin
        if (timer == '0) begin
          next_state = PSWR_H_HIGH;
          next_timer = TW'(HIGH_CYC - 1);
        end
      end
      PSWR_H_HIGH: begin
        if (timer == '0) begin
          next_state = PSWR_H_REL;
          next_timer = TW'(REL_CYC - 1);
        end
      end
      PSWR_H_REL: begin
        if (timer == '0) begin
          next_rx[5'(PSWR_PKT_MSB) - idx] = line_sync;
          next_idx = idx + 1'b1;
          if (idx + 1'b1 >= req) begin
            next_state = PSWR_H_END;
            next_timer = TW'(END_CYC - 1);
          end else begin
            next_state = PSWR_H_LOW;
            next_timer = TW'(LOW_CYC - 1);
          end
        end
      end
      PSWR_H_END: begin
        if (timer == '0) begin
          next_state = PSWR_H_IDLE;
          next_done = 1'b1;
          next_sig = rx[PSWR_PKT_MSB:PSWR_SIG_LSB];
          next_temp = rx[PSWR_SIG_LSB-1:0];
        end
      end
      default: begin
        next_state = PSWR_H_IDLE;
      end
    endcase
    // Line drive follows the phase being entered
    next_oe = (next_state != PSWR_H_IDLE) && (next_state != PSWR_H_REL);
    next_o = (next_state == PSWR_H_SETUP) || (next_state == PSWR_H_HIGH);
  end

  // Register sequencer state and pin drive
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= PSWR_H_IDLE;
      timer <= '0;
      ival <= '0;
      idx <= '0;
      req <= '0;
      rx <= '0;
      done <= 1'b0;
      sig_out <= '0;
      temp_out <= '0;
      link.host_o <= 1'b0;
      link.host_oe <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      timer <= next_timer;
      ival <= next_ival;
      idx <= next_idx;
      req <= next_req;
      rx <= next_rx;
      done <= next_done;
      sig_out <= next_sig;
      temp_out <= next_temp;
      link.host_o <= next_o;
      link.host_oe <= next_oe;
    end
  end

  assign busy = (state != PSWR_H_IDLE);

endmodule
`default_nettype wire

// File: verification/pswr_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pswr_checker #(
  parameter int FORCE_PERIOD = 512,
  parameter int SETUP_CYC = 20,
  parameter int LOW_CYC = 10,
  parameter int HIGH_CYC = 10,
  parameter int END_CYC = 60
) (
  input wire logic clk, // Host clock
  input wire logic dev_clk, // Link clock
  input wire logic reset, // Reset of both domains
  input wire logic host_o, // Host value
  input wire logic host_oe, // Host drives
  input wire logic dev_o, // Device value
  input wire logic dev_oe, // Device drives
  input wire logic shared_line_short // Resolved line
);
  int hi_cnt;
  int low_cnt;
  int edge_cnt;
  int idle_cnt;

  // ==========================================================
  // Helper counters
  // Host phase lengths and bit edges of the current frame
  always_ff @(posedge clk) begin
    if (reset) begin
      hi_cnt <= 0;
      low_cnt <= 0;
      edge_cnt <= 0;
    end else begin
      hi_cnt <= (host_oe && host_o) ? hi_cnt + 1 : 0;
      low_cnt <= (host_oe && !host_o) ? low_cnt + 1 : 0;
      if (host_oe && host_o && hi_cnt == 0)
        edge_cnt <= (low_cnt > 0) ? edge_cnt + 1 : 0;
    end
  end

  // Link cycles since the device last drove
  always_ff @(posedge dev_clk) begin
    if (reset)
      idle_cnt <= 0;
    else
      idle_cnt <= dev_oe ? 0 : idle_cnt + 1;
  end

  // ==========================================================
  // Assertions
  a_setup_length: assert property (@(posedge clk) disable iff (reset)
    host_oe && !host_o && $past(host_oe) && $past(host_o) |-> hi_cnt == SETUP_CYC)
    else $error("start high time wrong");
  a_low_time: assert property (@(posedge clk) disable iff (reset)
    host_oe && host_o && $past(host_oe) && !$past(host_o) |-> low_cnt == LOW_CYC)
    else $error("bit low time wrong");
  a_high_time: assert property (@(posedge clk) disable iff (reset)
    $fell(host_oe) && $past(host_o) |-> hi_cnt == HIGH_CYC)
    else $error("bit high time wrong");
  a_end_release: assert property (@(posedge clk) disable iff (reset)
    $fell(host_oe) && !$past(host_o) |-> low_cnt == END_CYC)
    else $error("closing low time wrong");
  a_bit_count: assert property (@(posedge clk) disable iff (reset)
    edge_cnt <= 28)
    else $error("too many bit edges");
  a_bit_after_edge: assert property (@(posedge dev_clk) disable iff (reset)
    $rose(dev_oe) && !dev_o |-> $past(shared_line_short) && !$past(shared_line_short, 6))
    else $error("data bit without rising edge");
  a_bit_window: assert property (@(posedge dev_clk) disable iff (reset)
    $rose(dev_oe) && !dev_o |-> dev_oe [*8])
    else $error("data bit window short");
  a_low_bound: assert property (@(posedge clk) disable iff (reset)
    low_cnt <= END_CYC)
    else $error("host low held too long");
  a_force_gap: assert property (@(posedge dev_clk) disable iff (reset)
    idle_cnt <= FORCE_PERIOD)
    else $error("forced high missing");
endmodule
`default_nettype wire

// File: verification/test_pyro_sensor_one_wire_readout.sv
`timescale 1ns/10ps
`default_nettype none
module test_pyro_sensor_one_wire_readout;
  localparam int SETUP_N = 20;
  localparam int END_N = 60;
  localparam int GAP_N = 2000;
  logic clk;
  logic dev_clk;
  logic reset;
  logic start;
  logic auto_en;
  logic [4:0] nbits;
  logic [13:0] sig_in;
  logic [13:0] temp_in;
  logic conv_short;
  logic dev_busy;
  logic host_busy;
  logic done;
  logic [13:0] sig_out;
  logic [13:0] temp_out;
  logic [31:0] lfsr;
  logic [27:0] exp_q[$];
  time done_t[$];
  int error_cnt = 0;
  int checked = 0;
  logic [4:0] nb_tab[10] = '{5'h1C, 5'h00, 5'h0E, 5'h01, 5'h1C, 5'h1B, 5'h0D, 5'h1F, 5'h02, 5'h1C};
  logic [13:0] rng_tab[6] = '{14'h3E01, 14'h3E00, 14'h01FE, 14'h01FF, 14'h3FFF, 14'h0000};
  logic [5:0] rng_exp = 6'h35;

  pswr_link_if link_bus ();

  // ==========================================================
  // Both ends and the checker
  pswr_device #(.LOW_END_CYCLES(8)) i_pswr_device (.dev_clk(dev_clk), .reset(reset),
    .ce(1'b1), .sig_in(sig_in), .temp_in(temp_in), .link(link_bus.dev),
    .conv_short(conv_short), .busy(dev_busy));
  pswr_host #(.SETUP_CYC(SETUP_N), .END_CYC(END_N), .INTERVAL_CYC(GAP_N)) i_pswr_host (
    .clk(clk), .reset(reset), .ce(1'b1), .start(start), .auto_en(auto_en), .nbits(nbits),
    .link(link_bus.host), .busy(host_busy), .done(done), .sig_out(sig_out),
    .temp_out(temp_out));
  pswr_checker #(.FORCE_PERIOD(pswr_pkg::PSWR_FORCE_PERIOD), .SETUP_CYC(SETUP_N),
    .LOW_CYC(pswr_pkg::PSWR_LOW_CYC), .HIGH_CYC(pswr_pkg::PSWR_HIGH_CYC), .END_CYC(END_N))
    i_pswr_checker (.clk(clk), .dev_clk(dev_clk), .reset(reset), .host_o(link_bus.host_o),
    .host_oe(link_bus.host_oe), .dev_o(link_bus.dev_o), .dev_oe(link_bus.dev_oe),
    .shared_line_short(link_bus.shared_line_short));

  // Host clock and link clock
  always #10 clk = ~clk;
  always #24 dev_clk = ~dev_clk;

  // ==========================================================
  // Model and helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Packet as read: unread low bits stay zero
  function automatic logic [27:0] model_pkt(input logic [13:0] s, input logic [13:0] t,
    input int n);
    logic [27:0] p;
    int k;
    p = {s, t};
    k = (n == 0 || n > 28) ? 28 : n;
    for (int i = 0; i < 28 - k; i++)
      p[i] = 1'b0;
    return p;
  endfunction

  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One read of n bits; chg inverts temp_in in mid-frame
  task automatic read_pkt(input logic [4:0] n, input bit chg);
    int w;
    w = 0;
    repeat (200) @(posedge clk);
    exp_q.push_back(model_pkt(sig_in, temp_in, int'(n)));
    nbits <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    while (done !== 1'b1 && w < 5000) begin
      @(posedge clk);
      if (chg && w == 200)
        temp_in <= ~temp_in;
      @(negedge clk);
      w++;
    end
    chk({27'h0, done}, 28'h1);
    chk({27'h0, host_busy}, 28'h0);
    chk({27'h0, dev_busy}, 28'h0);
  endtask

  // Every result against the model
  always @(negedge clk) begin
    if (done === 1'b1) begin
      done_t.push_back($time);
      chk({sig_out, temp_out}, exp_q.size() > 0 ? exp_q.pop_front() : ~{sig_out, temp_out});
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    clk = 1'b0;
    dev_clk = 1'b0;
    reset = 1'b1;
    start = 1'b0;
    auto_en = 1'b0;
    nbits = 5'h00;
    sig_in = 14'h2000;
    temp_in = 14'h1A2B;
    lfsr = 32'hC4C2;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    // Full and partial reads with edge and random data
    for (int i = 0; i < 10; i++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge clk);
      sig_in <= (i == 0) ? 14'h01FF : (i == 1) ? 14'h3E00 : 14'h01FF + 14'(lfsr % 32'h3C02);
      temp_in <= (i == 0) ? 14'h0000 : (i == 1) ? 14'h3FFF : lfsr[29:16];
      read_pkt(nb_tab[i], i == 4);
    end
    // Periodic reads at fixed spacing
    done_t.delete();
    repeat (4) exp_q.push_back(model_pkt(sig_in, temp_in, 28));
    @(posedge clk);
    nbits <= 5'h00;
    auto_en <= 1'b1;
    for (int w = 0; w < 12000 && done_t.size() < 4; w++)
      @(posedge clk);
    auto_en <= 1'b0;
    chk(28'(done_t.size()), 28'h4);
    chk(28'(done_t[2] - done_t[1]), 28'(done_t[3] - done_t[2]));
    // Out-of-range inputs short the converter
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      sig_in <= rng_tab[i];
      repeat (40) @(posedge dev_clk);
      @(posedge clk);
      sig_in <= 14'h2000;
      @(negedge clk);
      chk({27'h0, conv_short}, {27'h0, rng_exp[i]});
      repeat (440) @(posedge dev_clk);
      @(negedge clk);
      chk({27'h0, conv_short}, {27'h0, rng_exp[i]});
      repeat (120) @(posedge dev_clk);
      @(negedge clk);
      chk({27'h0, conv_short}, 28'h0);
    end
    end_sim();
  end

  // Cut a hang short
  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
